// File: hdl/dar_pkg.sv
// Shared constants, types and register map of the dual converter readout
package dar_pkg;

  // ------------------------------------------------------------------
  // Word layout
  // ------------------------------------------------------------------
  localparam int ADC_BITS  = 12;
  localparam int WORD_BITS = 16;
  localparam logic [ADC_BITS-1:0] CODE_FLIP = 12'h800;
  localparam logic             ID_ADC_A  = 1'b0;
  localparam logic             ID_ADC_B  = 1'b1;
  localparam logic             LEAD_BIT  = 1'b0;

  // ------------------------------------------------------------------
  // Frame sequencing, in serial clock falling edges; EDGE_RANGE counts edges of both kinds
  // ------------------------------------------------------------------
  localparam logic [5:0] FALL_PPD_MIN = 6'h02;
  localparam logic [5:0] FALL_PPD_MAX = 6'h09;
  localparam logic [5:0] FALL_WORD    = 6'h10;
  localparam logic [5:0] FALL_END     = 6'h20;
  localparam logic [3:0] EDGE_RANGE   = 4'h8;

  // ------------------------------------------------------------------
  // Quiet time between frames
  // ------------------------------------------------------------------
  localparam int QUIET_NS  = 200;
  localparam int CLK_NS    = 4;
  localparam int QUIET_CYC = (QUIET_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [5:0] QUIET_RST = 6'(QUIET_CYC);

  // ------------------------------------------------------------------
  // Result buffer
  // ------------------------------------------------------------------
  localparam int FIFO_WIDTH = 32;
  localparam int FIFO_DEPTH = 4;

  // ------------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ------------------------------------------------------------------
  localparam int            ADDR_W   = 12;
  localparam logic [11:0]   OFF_CTRL = 12'h000;
  localparam logic [11:0]   OFF_STAT = 12'h004;
  localparam logic [11:0]   OFF_DATA = 12'h008;
  localparam int CTRL_CAP_BIT  = 0;
  localparam int STAT_OVF_BIT  = 0;
  localparam int STAT_QERR_BIT = 1;
  localparam int STAT_PPD_BIT  = 2;
  localparam int STAT_OE_BIT   = 3;
  localparam int STAT_ST_LSB   = 4;
  localparam int STAT_LVL_LSB  = 8;
  localparam logic CTRL_CAP_RST = 1'b0;

  typedef enum logic [1:0] {
    SEL_CTRL = 2'b00,
    SEL_STAT = 2'b01,
    SEL_DATA = 2'b10,
    SEL_NONE = 2'b11
  } dar_sel_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_HOLD = 2'b10
  } dar_state_e;

  // Controls toward the analog converter pair
  typedef struct packed {
    logic start;
    logic step;
    logic chan;
    logic range;
    logic ref_ext;
    logic ppd;
  } dar_adc_ctl_s;

  // Held straight-binary samples from the analog converter pair
  typedef struct packed {
    logic [ADC_BITS-1:0] a;
    logic [ADC_BITS-1:0] b;
  } dar_adc_res_s;

endpackage : dar_pkg

// File: hdl/dar_fifo.sv
// Small flip-flop FIFO holding completed result pairs
`timescale 1ns/1ns
module dar_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4,
  parameter int PW    = $clog2(DEPTH),
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [CW-1:0]         level
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [CW-1:0]               count;
  } dar_fifo_s;

  dar_fifo_s q_ff;
  dar_fifo_s nxt_q;
  logic      do_push;
  logic      do_pop;

  assign in_ready  = (q_ff.count != CW'(DEPTH));
  assign out_valid = (q_ff.count != '0);
  assign out_data  = q_ff.mem[q_ff.rp];
  assign level     = q_ff.count;
  assign do_push   = in_valid & in_ready;
  assign do_pop    = out_valid & out_ready;

  always_comb begin
    nxt_q = q_ff;
    if (do_push) begin
      nxt_q.mem[q_ff.wp] = in_data;
      nxt_q.wp = (q_ff.wp == PW'(DEPTH - 1)) ? '0 : q_ff.wp + PW'(1);
    end
    if (do_pop) begin
      nxt_q.rp = (q_ff.rp == PW'(DEPTH - 1)) ? '0 : q_ff.rp + PW'(1);
    end
    case ({do_push, do_pop})
      2'b10:   nxt_q.count = q_ff.count + CW'(1);
      2'b01:   nxt_q.count = q_ff.count - CW'(1);
      default: nxt_q.count = q_ff.count;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

endmodule : dar_fifo

// File: hdl/dar_top.sv
// Serial frame control and readout of a dual sampling 12-bit converter
//
// Function
// R01: Active-low frame select; its fall starts both conversions, opens frame.
// R02: Range select level is caught at frame select fall for that conversion.
// R03: Range low: range zero to reference, straight binary result.
// R04: Range high: range zero to twice reference, two's complement result.
// R05: Range changed by eighth serial clock edge flips coding, range kept.
// R06: Output bits advance on serial clock falling edges.
// R07: Converter A drives output A, converter B output B, together.
// R08: Word is leading zero, three status bits, twelve data bits, MSB first.
// R09: Sixteen more clocks with frame low shift the other converter's word.
// R10: Serial clock alone paces the conversion steps.
// R11: Channel select picks the same channel on both converters together.
// R12: Channel select low converts channel 1, high converts channel 2.
// R13: Reference select low uses internal reference, high external reference.
// R14: Outputs float outside a frame, enabled only after frame select falls.
// R15: Host waits 200 ns after a read before the next frame.
// R16: Status bits name the converter whose result follows.
// R17: After 32 clocks with frame low, outputs float on 32nd falling edge.
// R18: Frame end between falling edges 2 and 9 aborts and powers down partly.
// R19: Host keeps range and channel select steady around frame select fall.
`timescale 1ns/1ns
module dar_top
  import dar_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int LW    = $clog2(DEPTH + 1)
) (
  input  wire logic                mclk,
  input  wire logic                reset_n,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                cs_n,
  input  wire logic                sclk,
  input  wire logic                range_sel,
  input  wire logic                channel_select,
  input  wire logic                ref_select,
  output logic                     serial_out_a,
  output logic                     serial_oe_a,
  output logic                     serial_out_b,
  output logic                     serial_oe_b,
  output dar_adc_ctl_s             adc_ctl,
  input  wire dar_adc_res_s        adc_res
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    dar_state_e           state;
    logic                 sclk_q;
    logic                 cs_q;
    logic [5:0]           falls;
    logic [3:0]           edges;
    logic [WORD_BITS-1:0] wa;
    logic [WORD_BITS-1:0] wb;
    logic [WORD_BITS-1:0] sh_a;
    logic [WORD_BITS-1:0] sh_b;
    logic                 range_cap;
    logic                 oe;
    logic [5:0]           quiet;
    logic                 quiet_err;
    logic                 ovf;
    logic                 cap_en;
    dar_adc_ctl_s         ctl;
    logic [31:0]          prdata;
  } dar_core_s;

  dar_core_s             q_ff;
  dar_core_s             nxt_q;
  logic                  cs_fall;
  logic                  cs_rise;
  logic                  sclk_fall;
  logic                  sclk_edge;
  logic                  apb_setup;
  logic                  apb_access;
  dar_sel_e              sel;
  logic                  push;
  logic [FIFO_WIDTH-1:0] push_data;
  logic                  buf_ready;
  logic                  buf_valid;
  logic                  buf_pop;
  logic [FIFO_WIDTH-1:0] buf_data;
  logic [LW-1:0]         buf_level;
  logic [ADC_BITS-1:0]   code_mask;
  logic [WORD_BITS-1:0]  flip_mask;
  logic [31:0]           stat_word;
  wire logic [1:0]       lane_out;
  wire logic [1:0]       lane_oe;

  function automatic dar_sel_e dar_decode(input logic [ADDR_W-1:0] a);
    dar_sel_e s;
    case (a)
      OFF_CTRL: s = SEL_CTRL;
      OFF_STAT: s = SEL_STAT;
      OFF_DATA: s = SEL_DATA;
      default:  s = SEL_NONE;
    endcase
    return s;
  endfunction : dar_decode

  // Shifter positions of the data MSB that are still unsent; the bit on
  // the pin is left alone so the pin only ever moves on a clock fall
  function automatic logic [WORD_BITS-1:0] dar_unsent(input logic [5:0] n);
    logic [WORD_BITS-1:0] m;
    m = WORD_BITS'({4'h0, CODE_FLIP} << n);
    m[WORD_BITS-1] = 1'b0;
    return m;
  endfunction : dar_unsent

  function automatic logic [WORD_BITS-1:0] dar_shift(
    input logic [WORD_BITS-1:0] w
  );
    return {w[WORD_BITS-2:0], 1'b0};
  endfunction : dar_shift

  // Two's complement differs from straight binary only in the MSB
  function automatic logic [ADC_BITS-1:0] dar_coding(input logic rg);
    return rg ? CODE_FLIP : '0;
  endfunction : dar_coding

  // ------------------------------------------------------------------
  // Pin events; pins are synchronous to mclk
  // ------------------------------------------------------------------
  assign cs_fall   = q_ff.cs_q & ~cs_n;  // [R01]
  assign cs_rise   = ~q_ff.cs_q & cs_n;
  assign sclk_fall = q_ff.sclk_q & ~sclk;
  assign sclk_edge = q_ff.sclk_q ^ sclk;

  // ------------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------------
  assign apb_setup  = psel & ~penable;
  assign apb_access = psel & penable;
  assign sel        = dar_decode(paddr);
  assign pready     = 1'b1;
  assign pslverr    = apb_access & (sel == SEL_NONE);
  assign prdata     = q_ff.prdata;
  // Head is latched at setup, popped at access, so a read sees one word
  assign buf_pop    = apb_access & ~pwrite & (sel == SEL_DATA);

  always_comb begin
    stat_word = '0;
    stat_word[STAT_OVF_BIT]  = q_ff.ovf;
    stat_word[STAT_QERR_BIT] = q_ff.quiet_err;
    stat_word[STAT_PPD_BIT]  = q_ff.ctl.ppd;
    stat_word[STAT_OE_BIT]   = q_ff.oe;
    stat_word[STAT_ST_LSB +: 2]  = q_ff.state;
    stat_word[STAT_LVL_LSB +: 8] = 8'(buf_level);
  end

  // ------------------------------------------------------------------
  // Pins out
  // ------------------------------------------------------------------
  // Lane 0 carries converter A then B, lane 1 converter B then A, in lockstep
  for (genvar g = 0; g < 2; g++) begin : g_lane
    if (g == 0) begin : g_a
      assign lane_out[g] = q_ff.sh_a[WORD_BITS-1];  // [R07]
    end else begin : g_b
      assign lane_out[g] = q_ff.sh_b[WORD_BITS-1];  // [R07]
    end
    // Both lanes float together whenever no frame holds them
    assign lane_oe[g] = q_ff.oe;  // [R14]
  end : g_lane

  assign serial_out_a = lane_out[0];
  assign serial_out_b = lane_out[1];
  assign serial_oe_a  = lane_oe[0];
  assign serial_oe_b  = lane_oe[1];
  assign adc_ctl      = q_ff.ctl;

  // Coding is fixed by the level caught at the frame start
  assign code_mask = dar_coding(range_sel);  // [R03] [R04]
  // A late coding change reaches only what has not reached the pin yet
  assign flip_mask = dar_unsent(q_ff.falls);  // [R05] [R06]

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    nxt_q = q_ff;
    push = 1'b0;
    push_data = '0;
    nxt_q.sclk_q = sclk;
    nxt_q.cs_q = cs_n;
    nxt_q.ctl.start = 1'b0;
    nxt_q.ctl.step = 1'b0;
    nxt_q.ctl.ref_ext = ref_select;  // [R13]

    // Bus read data is taken in the setup cycle
    if (apb_setup) begin
      case (sel)
        SEL_CTRL: nxt_q.prdata = {31'h0000_0000, q_ff.cap_en};
        SEL_STAT: nxt_q.prdata = stat_word;
        SEL_DATA: nxt_q.prdata = buf_valid ? buf_data : 32'h0000_0000;
        default:  nxt_q.prdata = 32'h0000_0000;
      endcase
    end

    // Bus writes first, so hardware sets below win over a clear
    if (apb_access && pwrite) begin
      case (sel)
        SEL_CTRL: nxt_q.cap_en = pwdata[CTRL_CAP_BIT];
        SEL_STAT: begin
          if (pwdata[STAT_OVF_BIT]) begin
            nxt_q.ovf = 1'b0;
          end
          if (pwdata[STAT_QERR_BIT]) begin
            nxt_q.quiet_err = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Quiet time runs while the outputs float
    if (!q_ff.oe && q_ff.quiet != QUIET_RST) begin
      nxt_q.quiet = q_ff.quiet + 6'h01;
    end

    if (cs_fall) begin
      // A frame started too soon is still served, but flagged
      if (q_ff.quiet != QUIET_RST) begin
        nxt_q.quiet_err = 1'b1;  // [R15]
      end
      nxt_q.state = ST_CONV;  // [R01]
      nxt_q.falls = '0;
      nxt_q.edges = '0;
      nxt_q.range_cap = range_sel;  // [R02]
      nxt_q.ctl.range = range_sel;  // [R02]
      nxt_q.ctl.chan = channel_select;  // [R11] [R12]
      nxt_q.ctl.start = 1'b1;  // [R01]
      nxt_q.ctl.ppd = 1'b0;
      nxt_q.oe = 1'b1;  // [R14]
      nxt_q.wa = {LEAD_BIT, ID_ADC_A, channel_select, range_sel,
                  adc_res.a ^ code_mask};  // [R08] [R16]
      nxt_q.wb = {LEAD_BIT, ID_ADC_B, channel_select, range_sel,
                  adc_res.b ^ code_mask};  // [R08] [R16]
      nxt_q.sh_a = nxt_q.wa;
      nxt_q.sh_b = nxt_q.wb;
      // A frame select edge outranks a serial clock fall in one cycle
    end else if (cs_rise) begin
      if (q_ff.state == ST_CONV && q_ff.falls >= FALL_PPD_MIN &&
          q_ff.falls <= FALL_PPD_MAX) begin
        nxt_q.ctl.ppd = 1'b1;  // [R18]
      end
      nxt_q.state = ST_IDLE;
      nxt_q.oe = 1'b0;  // [R14] [R18]
      nxt_q.quiet = '0;
    end else if (q_ff.state == ST_CONV) begin
      if (sclk_edge && q_ff.edges != EDGE_RANGE) begin
        nxt_q.edges = q_ff.edges + 4'h1;
        if (nxt_q.edges == EDGE_RANGE && range_sel != q_ff.range_cap) begin
          nxt_q.wa = q_ff.wa ^ {4'h0, CODE_FLIP};  // [R05]
          nxt_q.wb = q_ff.wb ^ {4'h0, CODE_FLIP};  // [R05]
          nxt_q.sh_a = q_ff.sh_a ^ flip_mask;  // [R05]
          nxt_q.sh_b = q_ff.sh_b ^ flip_mask;  // [R05]
        end
      end
      if (sclk_fall) begin
        nxt_q.falls = q_ff.falls + 6'h01;
        if (q_ff.falls < FALL_WORD) begin
          nxt_q.ctl.step = 1'b1;  // [R10]
        end
        if (nxt_q.falls == FALL_END) begin
          nxt_q.oe = 1'b0;  // [R17]
          nxt_q.state = ST_HOLD;
          nxt_q.quiet = '0;
        end else if (nxt_q.falls == FALL_WORD) begin
          // Each pin now carries the other converter's word
          nxt_q.sh_a = nxt_q.wb;  // [R09]
          nxt_q.sh_b = nxt_q.wa;  // [R09]
          push = 1'b1;
          push_data = {nxt_q.wa, nxt_q.wb};
        end else begin
          nxt_q.sh_a = dar_shift(nxt_q.sh_a);  // [R06]
          nxt_q.sh_b = dar_shift(nxt_q.sh_b);  // [R06]
        end
      end
    end

    // A full buffer drops the pair; the serial pins are never stalled
    if (push && q_ff.cap_en && !buf_ready) begin
      nxt_q.ovf = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      q_ff <= '0;
      q_ff.state <= ST_IDLE;
      // Edge detectors wake at the idle pin levels: no false edge
      q_ff.sclk_q <= 1'b1;
      q_ff.cs_q <= 1'b1;
      q_ff.quiet <= QUIET_RST;
      q_ff.cap_en <= CTRL_CAP_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ------------------------------------------------------------------
  // Result buffer
  // ------------------------------------------------------------------
  dar_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .in_valid  (push & q_ff.cap_en),
    .in_ready  (buf_ready),
    .in_data   (push_data),
    .out_valid (buf_valid),
    .out_ready (buf_pop),
    .out_data  (buf_data),
    .level     (buf_level)
  );

endmodule : dar_top

// File: verif/dar_top_props.sv
// Concurrent checks on the readout block's pins
`timescale 1ns/1ns
module dar_top_props
  import dar_pkg::*;
(
  input wire logic              mclk,
  input wire logic              reset_n,
  input wire logic              cs_n,
  input wire logic              sclk,
  input wire logic              range_sel,
  input wire logic              channel_select,
  input wire logic              ref_select,
  input wire logic              serial_out_a,
  input wire logic              serial_oe_a,
  input wire logic              serial_out_b,
  input wire logic              serial_oe_b,
  input wire dar_adc_ctl_s      adc_ctl
);
  logic       sclk_q_ff;
  logic       cs_q_ff;
  logic [5:0] falls_ff;
  logic       fall;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // ------------------------------------------------------------------
  // Falling edge count within the frame
  // ------------------------------------------------------------------
  assign fall = sclk_q_ff && !sclk && !cs_n;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_q_ff <= 1'b1;
      cs_q_ff   <= 1'b1;
      falls_ff  <= 6'h00;
    end else begin
      sclk_q_ff <= sclk;
      cs_q_ff   <= cs_n;
      if (cs_q_ff && !cs_n) begin
        falls_ff <= 6'h00;
      end else if (fall) begin
        falls_ff <= falls_ff + 6'h01;
      end
    end
  end

  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  sequence s_open;
    cs_q_ff && !cs_n;
  endsequence
  sequence s_lead;
    serial_oe_a && serial_oe_b && !serial_out_a && !serial_out_b
      && adc_ctl.start;
  endsequence

  a_frame_open: assert property (s_open |=> s_lead)
    else $error("frame open did not drive the lead bit");
  a_start_cause: assert property (adc_ctl.start |->
    $past(cs_n, 2) && !$past(cs_n))
    else $error("start pulse without frame select fall");
  a_step_cause: assert property (adc_ctl.step |->
    $past(sclk, 2) && !$past(sclk) && !$past(cs_n))
    else $error("step pulse without serial clock fall");
  a_shift_fall: assert property (serial_oe_a && $past(serial_oe_a)
    && ($changed(serial_out_a) || $changed(serial_out_b))
    |-> $past(sclk, 2) && !$past(sclk))
    else $error("output bit moved off a serial clock fall");
  a_oe_pair: assert property (serial_oe_a == serial_oe_b)
    else $error("output enables differ");
  a_idle_float: assert property (cs_n && $past(cs_n) |->
    !serial_oe_a && !serial_oe_b)
    else $error("output driven outside a frame");
  a_end_float: assert property (fall && falls_ff == 6'h1F |=>
    !serial_oe_a)
    else $error("output still driven after fall 32");
  a_ppd_abort: assert property (!cs_q_ff && cs_n
    && falls_ff >= FALL_PPD_MIN && falls_ff <= FALL_PPD_MAX
    |-> ##[1:2] adc_ctl.ppd)
    else $error("abort did not enter partial power-down");
  a_ctl_sample: assert property (s_open |=>
    adc_ctl.chan == $past(channel_select)
    && adc_ctl.range == $past(range_sel))
    else $error("channel or range not taken at frame open");
  a_ref_follow: assert property (adc_ctl.ref_ext == $past(ref_select))
    else $error("reference select not followed");
endmodule : dar_top_props

bind dar_top dar_top_props u_props (
  .mclk(mclk), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk),
  .range_sel(range_sel), .channel_select(channel_select),
  .ref_select(ref_select), .serial_out_a(serial_out_a),
  .serial_oe_a(serial_oe_a), .serial_out_b(serial_out_b),
  .serial_oe_b(serial_oe_b), .adc_ctl(adc_ctl)
);

// File: verif/dar_host_model.sv
// Host serial port model: frames, clocks and captures both outputs
`timescale 1ns/1ns
module dar_host_model (
  input  wire logic        mclk,
  output logic             cs_n,
  output logic             sclk,
  input  wire logic        serial_out_a,
  input  wire logic        serial_out_b,
  output logic [31:0]      cap_a,
  output logic [31:0]      cap_b
);
  // Serial clock idles high and stands still between frames
  initial begin
    cs_n  = 1'b1;
    sclk  = 1'b1;
    cap_a = 32'h0;
    cap_b = 32'h0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask : wt

  // Bit is taken just before each fall, where it has settled longest
  task automatic frame(input int nf);
    cs_n <= 1'b0;
    wt(4);
    for (int k = 0; k < nf; k++) begin
      cap_a <= {cap_a[30:0], serial_out_a};
      cap_b <= {cap_b[30:0], serial_out_b};
      sclk  <= 1'b0;
      wt(4);
      sclk  <= 1'b1;
      wt(4);
    end
    cs_n <= 1'b1;
    wt(60);
  endtask : frame
endmodule : dar_host_model

// File: verif/dual_adc_serial_readout_test.sv
// Self-checking bench of the dual converter readout
`timescale 1ns/1ns
module dual_adc_serial_readout_test;
  import dar_pkg::*;
  localparam logic [31:0] SM = 32'h0000FF0F;
  logic              mclk, reset_n, psel, penable, pwrite;
  logic              pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd, cap_a, cap_b;
  logic              cs_n, sclk, range_sel, channel_select, ref_select;
  logic              serial_out_a, serial_oe_a, serial_out_b, serial_oe_b;
  logic [31:0]       exp_q[$];
  dar_adc_ctl_s      adc_ctl;
  dar_adc_res_s      adc_res;
  int                bad_count, n_checks;

  dar_top dut (
    .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cs_n(cs_n), .sclk(sclk),
    .range_sel(range_sel), .channel_select(channel_select),
    .ref_select(ref_select), .serial_out_a(serial_out_a),
    .serial_oe_a(serial_oe_a), .serial_out_b(serial_out_b),
    .serial_oe_b(serial_oe_b), .adc_ctl(adc_ctl), .adc_res(adc_res)
  );
  dar_host_model u_host (
    .mclk(mclk), .cs_n(cs_n), .sclk(sclk), .serial_out_a(serial_out_a),
    .serial_out_b(serial_out_b), .cap_a(cap_a), .cap_b(cap_b)
  );

  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Zero-wait slave, but the wait loop keeps the master honest
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [15:0] wd(logic id, logic ch, logic rg,
                                     logic [11:0] d, logic fl);
    return {LEAD_BIT, id, ch, rg, (rg ^ fl) ? d ^ CODE_FLIP : d};
  endfunction : wd

  // One full 32-fall frame; fl moves range before the 8th edge, when the
  // data MSB of the first words already stands on the pins
  task automatic run(input logic rg, input logic ch, input logic fl);
    logic [15:0] wa, wb, wa0, wb0;
    wa  = wd(ID_ADC_A, ch, rg, adc_res.a, fl);
    wb  = wd(ID_ADC_B, ch, rg, adc_res.b, fl);
    wa0 = wd(ID_ADC_A, ch, rg, adc_res.a, 1'b0);
    wb0 = wd(ID_ADC_B, ch, rg, adc_res.b, 1'b0);
    @(posedge mclk);
    range_sel <= rg;
    channel_select <= ch;
    ref_select <= ch;
    repeat (2) @(posedge mclk);
    fork
      u_host.frame(32);
      if (fl) begin
        repeat (14) @(posedge mclk);
        range_sel <= ~rg;
      end
    join
    chk("pin_a", {wa0, wb}, cap_a);
    chk("pin_b", {wb0, wa}, cap_b);
    exp_q.push_back({wa, wb});
  endtask : run

  initial begin
    bad_count = 0;
    n_checks = 0;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    err = 1'b0;
    rd = 32'h0;
    range_sel = 1'b0;
    channel_select = 1'b0;
    ref_select = 1'b0;
    adc_res = {12'h5A3, 12'hC3E};
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    apb(1'b0, OFF_CTRL, 32'h0);
    chk("ctrl_reset", 32'h0, rd);
    apb(1'b0, OFF_STAT, 32'h0);
    chk("stat_reset", 32'h0, rd & SM);
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_read", 32'h0, rd);
    apb(1'b1, OFF_CTRL, 32'h1);
    for (int i = 0; i < 4; i++) begin
      run(i[0], i[1], 1'b0);
    end
    apb(1'b0, OFF_STAT, 32'h0);
    chk("stat_full", 32'h400, rd & SM);
    run(1'b0, 1'b1, 1'b1);
    apb(1'b0, OFF_STAT, 32'h0);
    chk("stat_overflow", 32'h401, rd & SM);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, OFF_DATA, 32'h0);
      chk("data_pop", exp_q[i], rd);
    end
    apb(1'b0, OFF_DATA, 32'h0);
    chk("data_empty", 32'h0, rd);
    apb(1'b1, OFF_STAT, 32'h1);
    apb(1'b0, OFF_STAT, 32'h0);
    chk("stat_clear", 32'h0, rd & SM);
    u_host.frame(5);
    apb(1'b0, OFF_STAT, 32'h0);
    chk("stat_abort", 32'h4, rd & SM);
    run(1'b1, 1'b0, 1'b0);
    apb(1'b0, OFF_STAT, 32'h0);
    chk("stat_resume", 32'h100, rd & SM);
    test_done;
  end

  // Six frames of about 320 cycles and one short frame of about 100, plus register traffic
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    test_done;
  end
endmodule : dual_adc_serial_readout_test
